// [rtl/dac_ctl_pkg.sv]
// Shared constants and state types for the two-wire control link.
// Assumes one fast-mode bus with this device and a single master logic end.
// Functional notes
// - Device is target only, never starts transfers
// - Address upper five bits fixed at 10011
// - Two low address bits come from straps
// - Respond only to own address, else silent
// - Master generates start, address, data, stop
// - Direction bit one reads, zero writes
// - Low acknowledge slot accepts, high refuses
// - Index byte first, then data, MSB first
// - Multi-byte write sends index once then data
// - Index advances by one per valid byte
// - Index past 4F wraps to 40
// - Undefined register access gets no acknowledge
// - Read preceded by index write, repeated start
// - Repeated start address equals earlier address
// - Read header acknowledged, selected register shifted out
// - Straps sampled only at reset release
package dac_ctl_pkg;
	localparam logic [4:0] DEV_ADDR_FIXED = 5'h13;
	localparam logic [7:0] INDEX_WRAP_TOP = 8'h4F;
	localparam logic [7:0] INDEX_WRAP_BASE = 8'h40;
	localparam logic [7:0] REG_FIRST = 8'h10;
	localparam logic [7:0] REG_LAST = 8'h19;
	localparam int REG_COUNT = 10;
	localparam logic [7:0] REG_MODE_RESET = 8'hC0;
	localparam logic [7:0] REG_OTHER_RESET = 8'h00;
	localparam logic [7:0] INDEX_RESET = 8'h00;
	localparam logic [3:0] BIT_COUNT = 4'h8;
	localparam logic RW_READ = 1'b1;
	localparam logic ACK_LEVEL = 1'b0;
	localparam int CLK_FREQ_KHZ = 10000;
	localparam int SCL_FREQ_KHZ = 400;
	// Least quarter period of the bus clock, rounded up
	localparam int SCL_QUARTER_CYCLES = (CLK_FREQ_KHZ + 4 * SCL_FREQ_KHZ - 1) / (4 * SCL_FREQ_KHZ);

	typedef enum logic [3:0] {
		D_IDLE = 4'h0,
		D_ADDR = 4'h1,
		D_ACK_ADDR = 4'h2,
		D_INDEX = 4'h3,
		D_ACK_INDEX = 4'h4,
		D_WDATA = 4'h5,
		D_ACK_WDATA = 4'h6,
		D_RDATA = 4'h7,
		D_ACK_RD = 4'h8
	} dev_state_t;

	typedef enum logic [2:0] {
		H_IDLE = 3'h0,
		H_START = 3'h1,
		H_TX = 3'h2,
		H_RX = 3'h3,
		H_STOP = 3'h4
	} host_state_t;
endpackage

// [rtl/i2c_link_if.sv]
// Open-drain two-wire link joining the master end and the device end.
// Assumes both ends only ever pull low; the wire level is resolved here.
`timescale 1ns/1ps
interface i2c_link_if;
	logic scl;
	logic sda;
	logic scl_host_out;
	logic scl_host_oe;
	logic sda_host_out;
	logic sda_host_oe;
	logic sda_dev_out;
	logic sda_dev_oe;

	// Wired-AND with pull-up: released lines read high
	assign scl = !(scl_host_oe && !scl_host_out);
	assign sda = !((sda_host_oe && !sda_host_out) || (sda_dev_oe && !sda_dev_out));

	modport dev_mp (
		input scl,
		input sda,
		output sda_dev_out,
		output sda_dev_oe
	);
	modport host_mp (
		input scl,
		input sda,
		output scl_host_out,
		output scl_host_oe,
		output sda_host_out,
		output sda_host_oe
	);
endinterface

// [rtl/dac_i2c_control_slave.sv]
// Device end: two-wire control target holding the mode control registers.
// Assumes link_clk oversamples the bus well above the bus clock rate.
`timescale 1ns/1ps
module dac_i2c_control_slave
	import dac_ctl_pkg::*;
(
	// Sampling clock and reset
	input wire logic link_clk,
	input wire logic rst,
	// Bus pins
	i2c_link_if.dev_mp bus,
	// Address straps
	input wire logic addr_strap_low,
	input wire logic addr_strap_high,
	// Register write report
	output logic wr_strobe,
	output logic [7:0] wr_index,
	output logic [7:0] wr_data
);
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic [1:0] strap_sync_low;
	logic [1:0] strap_sync_high;
	logic [1:0] rst_sync;
	logic rst_link;
	logic scl_prev;
	logic sda_prev;
	logic [1:0] strap_addr;
	logic strap_taken;
	dev_state_t state, next_state;
	logic [3:0] cnt, next_cnt;
	logic [7:0] shreg, next_shreg;
	logic [7:0] index, next_index;
	logic sda_oe, next_sda_oe;
	logic rd, next_rd;
	logic acked, next_acked;
	logic nack, next_nack;
	logic next_wr_strobe;
	logic [7:0] next_wr_index, next_wr_data;
	logic [7:0] regs [0:REG_COUNT-1];
	logic scl_rise, scl_fall, start_seen, stop_seen;
	logic [7:0] load_data;

	// True for indexes that name a real register
	function automatic logic is_defined(input logic [7:0] idx);
		return (idx >= REG_FIRST) && (idx <= REG_LAST);
	endfunction

	function automatic logic [7:0] advance(input logic [7:0] idx);
		return (idx == INDEX_WRAP_TOP) ? INDEX_WRAP_BASE : 8'(idx + 8'h01);
	endfunction

	// Array slot of a defined index
	function automatic logic [3:0] slot(input logic [7:0] idx);
		return 4'(idx - REG_FIRST);
	endfunction

	// Register contents, zero for undefined indexes
	function automatic logic [7:0] reg_value(input logic [7:0] idx);
		return is_defined(idx) ? regs[slot(idx)] : 8'h00;
	endfunction

	// target drives data only
	// The clock line is never driven, so this end cannot start a transfer
	assign bus.sda_dev_out = 1'b0;
	assign bus.sda_dev_oe = sda_oe;

	// Pin synchronisers; only the second stage feeds logic
	always_ff @(posedge link_clk)
	begin
		scl_sync <= {scl_sync[0], bus.scl};
		sda_sync <= {sda_sync[0], bus.sda};
		strap_sync_low <= {strap_sync_low[0], addr_strap_low};
		strap_sync_high <= {strap_sync_high[0], addr_strap_high};
		rst_sync <= {rst_sync[0], rst};
		scl_prev <= scl_sync[1];
		sda_prev <= sda_sync[1];
	end

	// Reset arrives from the system clock domain, so it is synchronised too
	assign rst_link = rst_sync[1];

	// Bus conditions from the synchronised lines
	assign scl_rise = scl_sync[1] && !scl_prev;
	assign scl_fall = !scl_sync[1] && scl_prev;
	assign start_seen = scl_sync[1] && scl_prev && sda_prev && !sda_sync[1];
	assign stop_seen = scl_sync[1] && scl_prev && !sda_prev && sda_sync[1];

	// strap capture after release
	// Straps are caught once, so later pin changes cannot move the address
	always_ff @(posedge link_clk)
	begin
		if (rst_link)
		begin
			strap_taken <= 1'b0;
			strap_addr <= 2'h0;
		end
		else if (!strap_taken)
		begin
			strap_taken <= 1'b1;
			strap_addr <= {strap_sync_high[1], strap_sync_low[1]};
		end
	end

	// Protocol next-state logic
	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		next_shreg = shreg;
		next_index = index;
		next_sda_oe = sda_oe;
		next_rd = rd;
		next_acked = acked;
		next_nack = nack;
		next_wr_strobe = 1'b0;
		next_wr_index = wr_index;
		next_wr_data = wr_data;
		load_data = 8'h00;
		if (start_seen)
		begin
			next_state = D_ADDR;
			next_cnt = 4'h0;
			next_sda_oe = 1'b0;
		end
		else if (stop_seen)
		begin
			next_state = D_IDLE;
			next_sda_oe = 1'b0;
		end
		else if (scl_rise)
		begin
			case (state)
				D_ADDR, D_INDEX, D_WDATA:
				begin
					if (cnt < BIT_COUNT)
					begin
						next_shreg = {shreg[6:0], sda_sync[1]};
						next_cnt = 4'(cnt + 4'h1);
					end
				end
				D_ACK_RD:
				begin
					next_nack = (sda_sync[1] != ACK_LEVEL);
				end
				default:
				begin
				end
			endcase
		end
		else if (scl_fall)
		begin
			case (state)
				D_ADDR:
				begin
					if (cnt == BIT_COUNT)
					begin
						if (strap_taken && shreg[7:1] == {DEV_ADDR_FIXED, strap_addr})
						begin
							next_rd = (shreg[0] == RW_READ);
							next_acked = (shreg[0] == RW_READ) ? is_defined(index) : 1'b1;
							next_sda_oe = next_acked;
							next_state = D_ACK_ADDR;
						end
						else
						begin
							next_state = D_IDLE;
						end
					end
				end
				D_ACK_ADDR:
				begin
					next_cnt = 4'h0;
					next_sda_oe = 1'b0;
					if (!acked)
					begin
						next_state = D_IDLE;
					end
					else if (rd)
					begin
						load_data = reg_value(index);
						next_shreg = load_data;
						next_sda_oe = !load_data[7];
						next_cnt = 4'h1;
						next_state = D_RDATA;
					end
					else
					begin
						next_state = D_INDEX;
					end
				end
				D_INDEX:
				begin
					if (cnt == BIT_COUNT)
					begin
						next_index = shreg;
						next_acked = is_defined(shreg);
						next_sda_oe = next_acked;
						next_state = D_ACK_INDEX;
					end
				end
				D_WDATA:
				begin
					if (cnt == BIT_COUNT)
					begin
						next_acked = is_defined(index);
						next_sda_oe = next_acked;
						if (next_acked)
						begin
							next_wr_strobe = 1'b1;
							next_wr_index = index;
							next_wr_data = shreg;
							next_index = advance(index);
						end
						next_state = D_ACK_WDATA;
					end
				end
				D_ACK_INDEX, D_ACK_WDATA:
				begin
					next_sda_oe = 1'b0;
					next_cnt = 4'h0;
					next_state = acked ? D_WDATA : D_IDLE;
				end
				D_RDATA:
				begin
					if (cnt == BIT_COUNT)
					begin
						next_sda_oe = 1'b0;
						next_state = D_ACK_RD;
					end
					else
					begin
						next_shreg = {shreg[6:0], 1'b0};
						next_sda_oe = !shreg[6];
						next_cnt = 4'(cnt + 4'h1);
					end
				end
				D_ACK_RD:
				begin
					if (nack)
					begin
						next_state = D_IDLE;
					end
					else
					begin
						next_index = advance(index);
						load_data = reg_value(next_index);
						next_shreg = load_data;
						next_sda_oe = !load_data[7];
						next_cnt = 4'h1;
						next_state = D_RDATA;
					end
				end
				default:
				begin
					next_state = D_IDLE;
				end
			endcase
		end
	end

	// Protocol state registers
	always_ff @(posedge link_clk)
	begin
		if (rst_link)
		begin
			state <= D_IDLE;
			cnt <= 4'h0;
			shreg <= 8'h00;
			index <= INDEX_RESET;
			sda_oe <= 1'b0;
			rd <= 1'b0;
			acked <= 1'b0;
			nack <= 1'b0;
			wr_strobe <= 1'b0;
			wr_index <= 8'h00;
			wr_data <= 8'h00;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			shreg <= next_shreg;
			index <= next_index;
			sda_oe <= next_sda_oe;
			rd <= next_rd;
			acked <= next_acked;
			nack <= next_nack;
			wr_strobe <= next_wr_strobe;
			wr_index <= next_wr_index;
			wr_data <= next_wr_data;
		end
	end

	// Mode register file; only complete, acknowledged bytes land here
	always_ff @(posedge link_clk)
	begin
		if (rst_link)
		begin
			for (int i = 0; i < REG_COUNT; i++)
			begin
				regs[i] <= (i == 0) ? REG_MODE_RESET : REG_OTHER_RESET;
			end
		end
		else if (next_wr_strobe)
		begin
			regs[slot(next_wr_index)] <= next_wr_data;
		end
	end
endmodule // dac_i2c_control_slave

// [rtl/dac_i2c_master.sv]
// Master end: runs one register write or one combined-format read per command.
// Assumes the clock is the system clock; bus clock is divided from it.
`timescale 1ns/1ps
module dac_i2c_master
	import dac_ctl_pkg::*;
#(
	parameter int QUARTER = SCL_QUARTER_CYCLES
)
(
	// System clock and reset
	input wire logic clock,
	input wire logic rst,
	// Bus pins
	i2c_link_if.host_mp bus,
	// Command request
	input wire logic cmd_valid,
	input wire logic cmd_read,
	input wire logic [6:0] cmd_dev_addr,
	input wire logic [7:0] cmd_index,
	input wire logic [7:0] cmd_wdata,
	output logic cmd_ready,
	// Command answer
	output logic done,
	output logic nack_err,
	output logic [7:0] rdata
);
	logic [1:0] sda_sync;
	host_state_t state, next_state;
	logic [7:0] div, next_div;
	logic [1:0] q, next_q;
	logic [3:0] bitn, next_bitn;
	logic [1:0] stage, next_stage;
	logic rd, next_rd;
	logic [6:0] dev, next_dev;
	logic [7:0] idx, next_idx;
	logic [7:0] wdat, next_wdat;
	logic [7:0] rx, next_rx;
	logic ack_bit, next_ack_bit;
	logic scl_oe, next_scl_oe;
	logic sda_oe, next_sda_oe;
	logic next_ready, next_done, next_nack_err;
	logic [7:0] next_rdata;
	logic [7:0] txbyte;
	logic tick;

	// Byte sent in each stage: write header, index, data, read header
	function automatic logic [7:0] stage_byte(input logic [1:0] s, input logic [6:0] a,
		input logic [7:0] i, input logic [7:0] d);
		case (s)
			2'h0: return {a, ~RW_READ};
			2'h1: return i;
			2'h2: return d;
			default: return {a, RW_READ};
		endcase
	endfunction

	assign bus.scl_host_out = 1'b0;
	assign bus.sda_host_out = 1'b0;
	assign bus.scl_host_oe = scl_oe;
	assign bus.sda_host_oe = sda_oe;
	assign txbyte = stage_byte(stage, dev, idx, wdat);
	assign tick = (div == 8'(QUARTER - 1));

	// Data line synchroniser; no stretching, so the clock line is not read
	always_ff @(posedge clock)
	begin
		sda_sync <= {sda_sync[0], bus.sda};
	end

	// Sequencer next-state logic
	always_comb
	begin
		next_state = state;
		next_div = (state == H_IDLE || tick) ? 8'h00 : 8'(div + 8'h01);
		next_q = (tick && state != H_IDLE) ? 2'(q + 2'h1) : q;
		next_bitn = bitn;
		next_stage = stage;
		next_rd = rd;
		next_dev = dev;
		next_idx = idx;
		next_wdat = wdat;
		next_rx = rx;
		next_ack_bit = ack_bit;
		next_ready = cmd_ready;
		next_done = 1'b0;
		next_nack_err = nack_err;
		next_rdata = rdata;
		// Pin levels per quarter of the current slot
		case (state)
			H_START:
			begin
				next_scl_oe = (q == 2'h0) || (q == 2'h3);
				next_sda_oe = (q >= 2'h2);
			end
			H_STOP:
			begin
				next_scl_oe = (q == 2'h0);
				next_sda_oe = (q <= 2'h1);
			end
			H_TX:
			begin
				next_scl_oe = (q == 2'h0) || (q == 2'h3);
				// MSB first, released in ack slot
				next_sda_oe = (bitn < BIT_COUNT) ? !txbyte[3'(7 - bitn)] : 1'b0;
			end
			H_RX:
			begin
				next_scl_oe = (q == 2'h0) || (q == 2'h3);
				next_sda_oe = 1'b0;
			end
			default:
			begin
				next_scl_oe = 1'b0;
				next_sda_oe = 1'b0;
			end
		endcase
		// Sampling at the end of the high middle quarter
		if (tick && q == 2'h2)
		begin
			if (state == H_TX && bitn == BIT_COUNT)
			begin
				next_ack_bit = sda_sync[1];
			end
			if (state == H_RX && bitn < BIT_COUNT)
			begin
				next_rx = {rx[6:0], sda_sync[1]};
			end
		end
		case (state)
			H_IDLE:
			begin
				next_q = 2'h0;
				// Ready whenever idle; drops on the accepting edge
				next_ready = 1'b1;
				if (cmd_valid && cmd_ready)
				begin
					next_ready = 1'b0;
					next_rd = cmd_read;
					next_dev = cmd_dev_addr;
					next_idx = cmd_index;
					next_wdat = cmd_wdata;
					next_stage = 2'h0;
					next_nack_err = 1'b0;
					next_state = H_START;
				end
			end
			H_START:
			begin
				if (tick && q == 2'h3)
				begin
					next_bitn = 4'h0;
					next_state = H_TX;
				end
			end
			H_TX:
			begin
				if (tick && q == 2'h3)
				begin
					if (bitn < BIT_COUNT)
					begin
						next_bitn = 4'(bitn + 4'h1);
					end
					else if (ack_bit != ACK_LEVEL)
					begin
						next_nack_err = 1'b1;
						next_state = H_STOP;
					end
					else
					begin
						next_bitn = 4'h0;
						case (stage)
							2'h0: next_stage = 2'h1;
							2'h1:
							begin
								next_stage = rd ? 2'h3 : 2'h2;
								next_state = rd ? H_START : H_TX;
							end
							2'h2: next_state = H_STOP;
							default: next_state = H_RX;
						endcase
					end
				end
			end
			H_RX:
			begin
				if (tick && q == 2'h3)
				begin
					if (bitn < BIT_COUNT)
					begin
						next_bitn = 4'(bitn + 4'h1);
					end
					else
					begin
						next_rdata = rx;
						next_state = H_STOP;
					end
				end
			end
			H_STOP:
			begin
				if (tick && q == 2'h3)
				begin
					next_done = 1'b1;
					next_ready = 1'b1;
					next_state = H_IDLE;
				end
			end
			default:
			begin
				next_state = H_IDLE;
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state <= H_IDLE;
			div <= 8'h00;
			q <= 2'h0;
			bitn <= 4'h0;
			stage <= 2'h0;
			rd <= 1'b0;
			dev <= 7'h00;
			idx <= 8'h00;
			wdat <= 8'h00;
			rx <= 8'h00;
			ack_bit <= 1'b1;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			cmd_ready <= 1'b0;
			done <= 1'b0;
			nack_err <= 1'b0;
			rdata <= 8'h00;
		end
		else
		begin
			state <= next_state;
			div <= next_div;
			q <= next_q;
			bitn <= next_bitn;
			stage <= next_stage;
			rd <= next_rd;
			dev <= next_dev;
			idx <= next_idx;
			wdat <= next_wdat;
			rx <= next_rx;
			ack_bit <= next_ack_bit;
			scl_oe <= next_scl_oe;
			sda_oe <= next_sda_oe;
			cmd_ready <= next_ready;
			done <= next_done;
			nack_err <= next_nack_err;
			rdata <= next_rdata;
		end
	end
endmodule // dac_i2c_master

// [bench/dac_link_checker.sv]
// Checker for the two-wire link: wire levels and the device's drive of the data line.
// Assumes it sits beside the link interface; straps are stable while reset is high.
`timescale 1ns/1ps
module dac_link_checker
	import dac_ctl_pkg::*;
(
	// Device clock and reset
	input wire logic link_clk,
	input wire logic rst,
	// Wire levels and device drive
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_dev_out,
	input wire logic sda_dev_oe,
	// Address straps
	input wire logic addr_strap_low,
	input wire logic addr_strap_high
);
	logic [1:0] strap_q;
	logic [7:0] cnt;
	logic [7:0] shreg;
	logic [7:0] hdr;
	logic [7:0] idx;
	logic scl_d;
	logic sda_d;
	logic [6:0] own;

	default clocking cb @(posedge link_clk); endclocking
	default disable iff (rst);

	assign own = {DEV_ADDR_FIXED, strap_q};

	// Bit count since start, shifted bits, header and index of the frame
	always_ff @(posedge link_clk)
	begin
		scl_d <= scl;
		sda_d <= sda;
		if (rst)
		begin
			strap_q <= {addr_strap_high, addr_strap_low};
			cnt <= 8'h00;
		end
		else if (scl && sda_d && !sda)
			cnt <= 8'h00;
		else if (scl && !scl_d)
		begin
			cnt <= cnt + 8'h01;
			shreg <= {shreg[6:0], sda};
			if (cnt == 8'h08)
				hdr <= shreg;
			if (cnt == 8'h11)
				idx <= shreg;
		end
	end

	sequence s_stop;
		scl && $rose(sda);
	endsequence
	sequence s_hdr_done;
		$rose(scl) && cnt == 8'h08;
	endsequence
	sequence s_idx_done;
		$rose(scl) && cnt == 8'h11;
	endsequence
	sequence s_data_done;
		$rose(scl) && cnt == 8'h1A;
	endsequence

	property p_low_only;
		sda_dev_oe |-> !sda_dev_out;
	endproperty
	a_low_only: assert property (p_low_only) else $error("device drives data line high");
	property p_hold_high;
		scl && $past(scl) |-> $stable(sda_dev_oe);
	endproperty
	a_hold_high: assert property (p_hold_high) else $error("device drive moved with clock high");
	property p_addr_quiet;
		cnt < 8'h08 |-> !sda_dev_oe;
	endproperty
	a_addr_quiet: assert property (p_addr_quiet) else $error("device drove during address");
	property p_fixed_bits;
		s_hdr_done ##0 (shreg[7:3] != DEV_ADDR_FIXED) |-> !sda_dev_oe;
	endproperty
	a_fixed_bits: assert property (p_fixed_bits) else $error("foreign address acknowledged");
	property p_own_ack;
		s_hdr_done |-> sda_dev_oe == (shreg[7:1] == own);
	endproperty
	a_own_ack: assert property (p_own_ack) else $error("address acknowledge wrong");
	property p_idx_ack;
		s_idx_done ##0 (hdr == {own, 1'b0}) |-> sda_dev_oe == (shreg >= REG_FIRST && shreg <= REG_LAST);
	endproperty
	a_idx_ack: assert property (p_idx_ack) else $error("index acknowledge wrong");
	property p_data_ack;
		s_data_done ##0 (hdr == {own, 1'b0} && idx >= REG_FIRST && idx <= REG_LAST) |-> sda_dev_oe;
	endproperty
	a_data_ack: assert property (p_data_ack) else $error("data byte not acknowledged");
	property p_master_slot;
		s_idx_done ##0 (hdr == {own, 1'b1}) |-> !sda_dev_oe;
	endproperty
	a_master_slot: assert property (p_master_slot) else $error("device drove master slot");
	property p_stop_free;
		s_stop |=> !sda_dev_oe [*8];
	endproperty
	a_stop_free: assert property (p_stop_free) else $error("device drove after stop");
endmodule // dac_link_checker

// [bench/testbench.sv]
// Testbench: master end and device end joined by the link, checked against a register model.
// Assumes the shortened bus clock quarter of 3 cycles and a free 32 ns device clock.
`timescale 1ns/1ps
module testbench;
	import dac_ctl_pkg::*;
	logic clock;
	logic link_clk;
	logic rst;
	logic addr_strap_low;
	logic addr_strap_high;
	logic cmd_valid;
	logic cmd_read;
	logic [6:0] cmd_dev_addr;
	logic [7:0] cmd_index;
	logic [7:0] cmd_wdata;
	logic cmd_ready;
	logic done;
	logic nack_err;
	logic [7:0] rdata;
	logic wr_strobe;
	logic [7:0] wr_index;
	logic [7:0] wr_data;
	int mismatches = 0;
	int total_checks = 0;
	int unsigned seed = 70;
	int unsigned r;
	int regs[10];
	logic [1:0] own;
	logic [15:0] wq[$];
	logic [7:0] hdrs[$];
	logic [7:0] sh;
	int bit_n = 0;

	i2c_link_if link();
	dac_i2c_master #(.QUARTER(3)) dac_i2c_master_inst (.clock(clock), .rst(rst), .bus(link),
		.cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_dev_addr(cmd_dev_addr),
		.cmd_index(cmd_index), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .done(done),
		.nack_err(nack_err), .rdata(rdata));
	dac_i2c_control_slave dac_i2c_control_slave_inst (.link_clk(link_clk), .rst(rst), .bus(link),
		.addr_strap_low(addr_strap_low), .addr_strap_high(addr_strap_high),
		.wr_strobe(wr_strobe), .wr_index(wr_index), .wr_data(wr_data));
	dac_link_checker dac_link_checker_inst (.link_clk(link_clk), .rst(rst), .scl(link.scl),
		.sda(link.sda), .sda_dev_out(link.sda_dev_out), .sda_dev_oe(link.sda_dev_oe),
		.addr_strap_low(addr_strap_low), .addr_strap_high(addr_strap_high));

	// Clocks; odd offset keeps the two clocks' edges apart
	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	initial
	begin
		link_clk = 1'b0;
		#7;
		forever #16 link_clk = ~link_clk;
	end

	// Register writes reported by the device
	always @(posedge link_clk)
		if (wr_strobe === 1'b1)
			wq.push_back({wr_index, wr_data});
	// Wire monitor: header byte of each frame as seen on the wire
	always @(negedge link.sda)
		if (link.scl === 1'b1)
			bit_n = 0;
	always @(posedge link.scl)
	begin
		sh = {sh[6:0], link.sda};
		bit_n = bit_n + 1;
		if (bit_n == 8)
			hdrs.push_back(sh);
	end

	function automatic int unsigned xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Reset both ends; the model takes the straps and reset values
	task automatic do_reset();
		@(posedge clock);
		rst <= 1'b1;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		foreach (regs[i])
			regs[i] = 0;
		regs[0] = 32'h000000C0;
		own = {addr_strap_high, addr_strap_low};
	endtask

	// One command; waits are bounded and a hang ends the run
	task automatic do_cmd(input logic rd, input logic [6:0] a, input logic [7:0] i, input logic [7:0] d);
		int n;
		logic ok;
		ok = (a == {DEV_ADDR_FIXED, own}) && i >= REG_FIRST && i <= REG_LAST;
		wq.delete();
		hdrs.delete();
		@(posedge clock);
		cmd_valid <= 1'b1;
		cmd_read <= rd;
		cmd_dev_addr <= a;
		cmd_index <= i;
		cmd_wdata <= d;
		n = 0;
		do begin @(posedge clock); n++; end while (cmd_ready !== 1'b1 && n < 50);
		cmd_valid <= 1'b0;
		do begin @(posedge clock); n++; end while (done !== 1'b1 && n < 4000);
		if (done !== 1'b1)
		begin
			mismatches++;
			stop_test();
		end
		check({15'h0000, nack_err}, {15'h0000, !ok});
		check({8'h00, hdrs.size() > 0 ? hdrs[0] : 8'h00}, {8'h00, a, 1'b0});
		check({14'h0000, link.scl, link.sda}, 16'h0003);
		// Clock rises since the last start: 27 bits and stop for a write, 18 and stop for a read
		if (ok && !rd)
			check(16'(bit_n), 16'h001C);
		if (ok && rd)
			check(16'(bit_n), 16'h0013);
		if (rd && ok)
		begin
			check({8'h00, rdata}, 16'(regs[i - 8'h10]));
			check({8'h00, hdrs.size() > 1 ? hdrs[1] : 8'h00}, {8'h00, a, 1'b1});
		end
		if (!rd)
			check(16'(wq.size()), {15'h0000, ok});
		if (!rd && ok)
		begin
			check(wq.size() > 0 ? wq[0] : 16'h0000, {i, d});
			regs[i - 8'h10] = d;
		end
	endtask

	// Main sequence: reset values, random traffic, strap changes
	initial
	begin
		rst = 1'b1;
		addr_strap_low = 1'b0;
		addr_strap_high = 1'b1;
		cmd_valid = 1'b0;
		cmd_read = 1'b0;
		cmd_dev_addr = 7'h00;
		cmd_index = 8'h00;
		cmd_wdata = 8'h00;
		do_reset();
		do_cmd(1'b1, {DEV_ADDR_FIXED, own}, 8'h10, 8'h00);
		do_cmd(1'b1, {DEV_ADDR_FIXED, own}, 8'h19, 8'h00);
		repeat (40)
		begin
			r = xs();
			do_cmd(r[0], r[3:2] != 2'h0 ? {DEV_ADDR_FIXED, own} : r[14:8],
				r[6:4] != 3'h0 ? REG_FIRST + 8'(r[23:16] % 10) : r[31:24], 8'(xs()));
		end
		// Straps only count from the next reset on
		for (int k = 0; k < 4; k++)
		begin
			@(posedge clock);
			{addr_strap_high, addr_strap_low} <= 2'(k);
			do_cmd(1'b0, {DEV_ADDR_FIXED, own}, 8'h12, 8'(k));
			do_cmd(1'b0, {DEV_ADDR_FIXED, 2'(k + 1)}, 8'h12, 8'h5A);
			do_reset();
			do_cmd(1'b1, {DEV_ADDR_FIXED, own}, 8'h10, 8'h00);
			do_cmd(1'b0, {DEV_ADDR_FIXED, own}, 8'h11, 8'(k));
			do_cmd(1'b1, {DEV_ADDR_FIXED, own}, 8'h11, 8'h00);
		end
		stop_test();
	end
endmodule // testbench
